// >>> adcr_readout.sv
// Result readout port of a 14-bit converter: core conversion control,
// result holding and the serial link shifting the result to the host.
// Assumes the host keeps chip select low at least three mclk periods
// before the first falling serial clock edge, and does not clock a frame
// while a conversion is still running.
`timescale 1ns/1ns
`include "adcr_consts.svh"
module adcr_readout
    import adcr_pkg::*;
#(
    parameter int CONV_CYCLES = `ADCR_CONV_CYC_DEF
) (
    // Core clock and reset.
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // Serial link pins.
    input  wire logic                   sclk,
    input  wire logic                   cs_n,
    output logic                        dout,
    output logic                        dout_oe_n,
    // Conversion request and analog result.
    input  wire logic                   conv_start,
    input  wire logic [`ADCR_RES_W-1:0] adc_code,
    input  wire logic                   trailing_status_bit_hi,
    input  wire logic                   trailing_status_bit_lo,
    // Status.
    output logic                        powered,
    output logic                        conv_busy,
    output logic                        conv_abort,
    output logic                        result_fresh,
    output logic                        sclk_overspeed
);
    // The conversion counter is eight bits wide.
    if (CONV_CYCLES < 1 || CONV_CYCLES > 256) begin : g_bad_conv
        $error("CONV_CYCLES must lie in 1 to 256.");
    end

    adcr_link_if link_if ();

    logic [2:0]                sync_out;
    logic                      cs_s;
    logic                      started_s;
    logic                      sclk_s;

    adcr_state_t               state_ff;
    adcr_state_t               nxt_state;
    logic [7:0]                cnt_ff;
    logic [7:0]                nxt_cnt;
    logic                      abort_ff;
    logic                      nxt_abort;
    logic [`ADCR_WORD_W-1:0]   pend_ff;
    logic [`ADCR_WORD_W-1:0]   nxt_pend;
    logic                      pend_v_ff;
    logic                      nxt_pend_v;
    logic [`ADCR_WORD_W-1:0]   word_ff;
    logic [`ADCR_WORD_W-1:0]   nxt_word;
    logic                      fresh_ff;
    logic                      nxt_fresh;

    logic                      sclk_prev_ff;
    logic                      nxt_sclk_prev;
    logic [7:0]                gap_ff;
    logic [7:0]                nxt_gap;
    logic                      seen_ff;
    logic                      nxt_seen;
    logic                      over_ff;
    logic                      nxt_over;
    logic                      rise;

    // Chip select, frame start and serial clock enter the core domain.
    adcr_sync #(
        .WIDTH   (3),
        .RST_VAL (`ADCR_SYNC_RST)
    ) u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in ({sclk, link_if.started, cs_n}),
        .sync_out (sync_out)
    );

    assign cs_s      = sync_out[0];
    assign started_s = sync_out[1];
    assign sclk_s    = sync_out[2];

    // The serial side runs on the host's clock and is cleared by cs_n.
    adcr_shifter u_shifter (
        .sclk (sclk),
        .cs_n (cs_n),
        .dout (dout),
        .lnk  (link_if.link)
    );

    // The leading byte is constant zero; the rest is the held result.
    assign link_if.word = {`ADCR_LEAD_BYTE, word_ff};

    // The pin is released as soon as chip select rises, with no clock.
    assign dout_oe_n = cs_n;

    // Conversion control and result holding.
    // The shift word changes only while no frame has begun shifting, so
    // the serial side never sees it move; a result finished meanwhile
    // waits in the pending register instead of being lost.
    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_abort  = 1'b0;
        nxt_pend   = pend_ff;
        nxt_pend_v = pend_v_ff;
        nxt_word   = word_ff;
        nxt_fresh  = fresh_ff;
        if (started_s) begin
            nxt_fresh = 1'b0;
        end
        if (pend_v_ff && !started_s) begin
            nxt_word   = pend_ff;
            nxt_pend_v = 1'b0;
            nxt_fresh  = 1'b1;
        end
        unique case (state_ff)
            ADCR_SHUT: begin
                if (!cs_s) begin
                    nxt_state = ADCR_READY;
                end
            end
            ADCR_READY: begin
                if (cs_s) begin
                    nxt_state = ADCR_SHUT;
                end else if (conv_start) begin
                    nxt_state = ADCR_CONV;
                    nxt_cnt   = 8'(CONV_CYCLES - 1);
                end
            end
            ADCR_CONV: begin
                if (cs_s) begin
                    nxt_state = ADCR_SHUT;
                    nxt_abort = 1'b1;
                end else if (cnt_ff == 8'h00) begin
                    nxt_state  = ADCR_READY;
                    // Code passes as straight binary, status bits last.
                    nxt_pend   = {adc_code, trailing_status_bit_hi,
                                  trailing_status_bit_lo};
                    nxt_pend_v = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
        endcase
    end

    // Register the conversion group.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff  <= ADCR_SHUT;
            cnt_ff    <= 8'h00;
            abort_ff  <= 1'b0;
            pend_ff   <= '0;
            pend_v_ff <= 1'b0;
            word_ff   <= '0;
            fresh_ff  <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            abort_ff  <= nxt_abort;
            pend_ff   <= nxt_pend;
            pend_v_ff <= nxt_pend_v;
            word_ff   <= nxt_word;
            fresh_ff  <= nxt_fresh;
        end
    end

    // Serial clock rate watch: rising edges closer than the 4.8 MHz
    // period allows raise a flag held until chip select rises. Sampling
    // jitter costs a cycle, so only clear overspeed is caught.
    assign rise = sclk_s && !sclk_prev_ff;

    always_comb begin
        nxt_sclk_prev = sclk_s;
        nxt_gap       = gap_ff;
        nxt_seen      = seen_ff;
        nxt_over      = over_ff;
        if (gap_ff != `ADCR_GAP_MAX) begin
            nxt_gap = gap_ff + 8'h01;
        end
        if (rise) begin
            nxt_gap  = 8'h00;
            nxt_seen = 1'b1;
        end
        if (cs_s) begin
            nxt_seen = 1'b0;
            nxt_over = 1'b0;
        end else if (rise && seen_ff &&
                     gap_ff < 8'(`ADCR_SCLK_MIN_GAP)) begin
            nxt_over = 1'b1;
        end
    end

    // Register the rate watch.
    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_prev_ff <= 1'b0;
            gap_ff       <= 8'h00;
            seen_ff      <= 1'b0;
            over_ff      <= 1'b0;
        end else begin
            sclk_prev_ff <= nxt_sclk_prev;
            gap_ff       <= nxt_gap;
            seen_ff      <= nxt_seen;
            over_ff      <= nxt_over;
        end
    end

    assign powered        = (state_ff != ADCR_SHUT);
    assign conv_busy      = (state_ff == ADCR_CONV);
    assign conv_abort     = abort_ff;
    assign result_fresh   = fresh_ff;
    assign sclk_overspeed = over_ff;

    // A conversion finishing with an idle link and nothing pending.
    sequence seq_done_free;
        state_ff == ADCR_CONV && cnt_ff == 8'h00 && !cs_s &&
        !started_s && !pend_v_ff;
    endsequence

    // The link staying idle for the transfer cycle.
    sequence seq_link_idle;
        !started_s;
    endsequence

    chk_power_up: assert property (@(posedge mclk) disable iff (rst)
        state_ff == ADCR_SHUT && !cs_s |=> powered)
        else $error("Chip select low did not power up.");

    chk_abort_shut: assert property (@(posedge mclk) disable iff (rst)
        conv_busy && cs_s |=> !powered && conv_abort ##1 !conv_abort)
        else $error("Conversion not aborted on chip select rise.");

    chk_no_start_off: assert property (@(posedge mclk) disable iff (rst)
        !powered |=> !conv_busy)
        else $error("Conversion started while shut down.");

    chk_top_byte: assert property (@(posedge mclk) disable iff (rst)
        seq_done_free ##1 seq_link_idle
        |=> word_ff[15:8] == $past(adc_code[13:6], 2))
        else $error("Second byte does not hold the top bits.");

    chk_low_byte: assert property (@(posedge mclk) disable iff (rst)
        seq_done_free ##1 seq_link_idle
        |=> word_ff[7:0] == {$past(adc_code[5:0], 2),
            $past(trailing_status_bit_hi, 2),
            $past(trailing_status_bit_lo, 2)})
        else $error("Third byte layout wrong.");

    chk_word_frozen: assert property (@(posedge mclk) disable iff (rst)
        started_s && $past(started_s) |-> $stable(word_ff))
        else $error("Shift word changed during a frame.");

    chk_pend_kept: assert property (@(posedge mclk) disable iff (rst)
        pend_v_ff && started_s |=> pend_v_ff)
        else $error("Pending result dropped during a frame.");

    chk_rate_flag: assert property (@(posedge mclk) disable iff (rst)
        rise && seen_ff && !cs_s && gap_ff < 8'(`ADCR_SCLK_MIN_GAP)
        |=> sclk_overspeed)
        else $error("Fast serial clock not flagged.");

    chk_rate_clear: assert property (@(posedge mclk) disable iff (rst)
        cs_s |=> !sclk_overspeed)
        else $error("Overspeed flag survived frame end.");

    chk_zero_lead: assert property (@(posedge mclk) disable iff (rst)
        link_if.word[`ADCR_STREAM_BITS-1:`ADCR_WORD_W] == 8'h00)
        else $error("Leading byte of the word not zero.");

    // A conversion request that the ready state accepts.
    sequence seq_take;
        state_ff == ADCR_READY && !cs_s && conv_start;
    endsequence

    // Start, shutdown and abort of a conversion.
    chk_start_taken: assert property (@(posedge mclk)
        disable iff (rst) seq_take
        |=> conv_busy && cnt_ff == 8'(CONV_CYCLES - 1))
        else $error("Accepted request did not start a conversion.");

    chk_cs_shut: assert property (@(posedge mclk)
        disable iff (rst) cs_s |=> !powered)
        else $error("Chip select high did not shut down.");

    chk_abort_cause: assert property (@(posedge mclk)
        disable iff (rst) conv_abort |-> $past(conv_busy) && $past(cs_s))
        else $error("Abort raised without a running conversion.");

    // Hand-over of a finished result into the shift word.
    chk_pend_set: assert property (@(posedge mclk)
        disable iff (rst) seq_done_free |=> pend_v_ff)
        else $error("Finished result not held as pending.");

    chk_word_load: assert property (@(posedge mclk)
        disable iff (rst) pend_v_ff && !started_s
        |=> word_ff == $past(pend_ff) && result_fresh)
        else $error("Pending result not moved into the shift word.");

    chk_fresh_clear: assert property (@(posedge mclk)
        disable iff (rst) started_s && !pend_v_ff |=> !result_fresh)
        else $error("Fresh flag kept after the frame began.");
endmodule // adcr_readout

// >>> adcr_consts.svh
// Constants for the converter result readout port.
// Assumes inclusion by bare name from every design file that needs them.
// What this block does
// - Link uses clock idle low, data sampled on rising edge.
// - One result takes three back-to-back byte transfers.
// - Output changes on falling edge; host captures on next rising edge.
// - First result byte is all zeros.
// - Second byte holds result bits thirteen down to six.
// - Third byte holds bits five to zero, then high, low status bits.
// - Serial clock must not exceed 4.8 MHz.
// - Result is straight unsigned binary, zero at ground.
// - Chip select rising during conversion aborts it and shuts down.
`ifndef ADCR_CONSTS_SVH
`define ADCR_CONSTS_SVH
`define ADCR_RES_W           14
`define ADCR_WORD_W          16
`define ADCR_STREAM_BITS     24
`define ADCR_CNT_W           5
`define ADCR_LEAD_BYTE       8'h00
`define ADCR_MCLK_KHZ        25000
`define ADCR_SCLK_MAX_KHZ    4800
`define ADCR_SCLK_MIN_GAP    ((`ADCR_MCLK_KHZ / `ADCR_SCLK_MAX_KHZ) - 2)
`define ADCR_GAP_MAX         8'hFF
`define ADCR_CONV_CYC_DEF    16
`define ADCR_SYNC_RST        3'h1
`endif

// >>> adcr_pkg.sv
// Types shared by the readout port modules.
// Assumes nothing beyond a SystemVerilog compiler.
package adcr_pkg;
    typedef enum logic [1:0] {
        ADCR_SHUT,
        ADCR_READY,
        ADCR_CONV
    } adcr_state_t;
endpackage

// >>> adcr_link_if.sv
// Carrier between the core domain and the serial shifter.
// Assumes the word is held stable by the core while a frame shifts.
`timescale 1ns/1ns
`include "adcr_consts.svh"
interface adcr_link_if;
    logic [`ADCR_STREAM_BITS-1:0] word;
    logic                         started;
    modport core (output word, input started);
    modport link (input word, output started);
endinterface

// >>> adcr_sync.sv
// Two-stage level synchroniser for signals entering the core domain.
// Assumes inputs are levels that hold for at least two clock periods.
`timescale 1ns/1ns
module adcr_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             rst,
    // Levels in and out.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // The first stage feeds only the second stage.
    always_comb begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    // Register both stages.
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff;
endmodule // adcr_sync

// >>> adcr_shifter.sv
// Serial shifter clocked by the host's serial clock.
// Assumes chip select high clears it and the word is stable in a frame.
`timescale 1ns/1ns
`include "adcr_consts.svh"
module adcr_shifter (
    // Link pins.
    input  wire logic sclk,
    input  wire logic cs_n,
    output logic      dout,
    // Core side.
    adcr_link_if.link lnk
);
    logic [`ADCR_CNT_W-1:0] cnt_ff;
    logic [`ADCR_CNT_W-1:0] nxt_cnt;
    logic [`ADCR_CNT_W-1:0] idx;
    logic                   dout_ff;
    logic                   nxt_dout;
    logic                   started_ff;

    // Next bit: stream index falls by one per falling edge, zeros after.
    always_comb begin
        idx      = `ADCR_CNT_W'(`ADCR_STREAM_BITS - 2) - cnt_ff;
        nxt_cnt  = cnt_ff;
        nxt_dout = 1'b0;
        if (cnt_ff < `ADCR_CNT_W'(`ADCR_STREAM_BITS - 1)) begin
            nxt_dout = lnk.word[idx];
        end
        if (cnt_ff != `ADCR_CNT_W'(`ADCR_STREAM_BITS)) begin
            nxt_cnt = cnt_ff + `ADCR_CNT_W'(1);
        end
    end

    // Output moves on the falling edge so the host samples it on the rise.
    // Chip select high ends the frame even with the clock standing still.
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_ff     <= '0;
            dout_ff    <= 1'b0;
            started_ff <= 1'b0;
        end else begin
            cnt_ff     <= nxt_cnt;
            dout_ff    <= nxt_dout;
            started_ff <= 1'b1;
        end
    end

    assign dout        = dout_ff;
    assign lnk.started = started_ff;

    chk_lead_zero: assert property (@(negedge sclk) disable iff (cs_n)
        cnt_ff < `ADCR_CNT_W'(7) |=> !dout_ff)
        else $error("Leading byte bit not zero.");

    chk_msb_order: assert property (@(negedge sclk) disable iff (cs_n)
        cnt_ff < `ADCR_CNT_W'(`ADCR_STREAM_BITS - 1)
        |=> dout_ff == $past(lnk.word[idx]))
        else $error("Serial bit out of order.");

    chk_tail_zero: assert property (@(negedge sclk) disable iff (cs_n)
        cnt_ff >= `ADCR_CNT_W'(`ADCR_STREAM_BITS - 1) |=> !dout_ff)
        else $error("Extra clocks did not give zeros.");
endmodule // adcr_shifter

// >>> adcr_host_model.sv
// Host serial master model that reads results from the readout port.
// Assumes osc runs free; the serial clock is osc divided by 2*half.
`timescale 1ns/1ns
module adcr_host_model (
    // Oscillator and bench control.
    input  wire logic        osc,
    input  wire logic        sel,
    input  wire logic        go,
    input  int               half,
    input  int               nbits,
    // Link pins.
    output logic             cs_n,
    output logic             sclk,
    input  wire logic        dout,
    // Received stream.
    output logic             done,
    output logic [31:0]      rx
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        done = 1'b0;
        rx   = 32'h0000_0000;
    end

    // Chip select follows the bench request; it is high before any work.
    always @(posedge osc) begin
        cs_n <= !sel;
    end

    // One frame: clock idles low, each bit is taken on the rising edge.
    // With half at 8 the serial clock is osc/16, well under the limit.
    always begin
        wait (go === 1'b1);
        rx <= 32'h0000_0000;
        // Extra lead-in keeps chip select ahead of the first falling edge.
        repeat (4) @(posedge osc);
        for (int i = 0; i < nbits; i++) begin
            repeat (half) @(posedge osc);
            sclk <= 1'b1;
            rx   <= {rx[30:0], dout};
            repeat (half) @(posedge osc);
            sclk <= 1'b0;
        end
        done <= 1'b1;
        wait (go === 1'b0);
        @(posedge osc);
        done <= 1'b0;
    end
endmodule // adcr_host_model

// >>> adcr_readout_tb.sv
// Self-checking bench for the result readout port.
// Assumes the host model in its own file and a 48 ns host oscillator.
`timescale 1ns/1ns
module adcr_readout_tb;
    localparam int CONV = 12;
    // Clocks, reset and stimulus.
    logic        mclk;
    logic        osc;
    logic        rst;
    logic        sel;
    logic        go;
    int          half;
    int          nbits;
    logic        conv_start;
    logic [13:0] adc_code;
    logic        st_hi;
    logic        st_lo;
    // Link and status.
    logic        sclk;
    logic        cs_n;
    logic        dout;
    logic        dout_oe_n;
    logic        powered;
    logic        conv_busy;
    logic        conv_abort;
    logic        result_fresh;
    logic        sclk_overspeed;
    logic        done;
    logic [31:0] rx;
    int          miscompares;
    int          n_checks;
    int          seed;
    int          exp_q[$];

    adcr_readout #(.CONV_CYCLES(CONV)) adcr_readout_inst (
        .mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .dout(dout),
        .dout_oe_n(dout_oe_n), .conv_start(conv_start),
        .adc_code(adc_code), .trailing_status_bit_hi(st_hi),
        .trailing_status_bit_lo(st_lo), .powered(powered),
        .conv_busy(conv_busy), .conv_abort(conv_abort),
        .result_fresh(result_fresh), .sclk_overspeed(sclk_overspeed)
    );

    adcr_host_model adcr_host_model_inst (
        .osc(osc), .sel(sel), .go(go), .half(half), .nbits(nbits),
        .cs_n(cs_n), .sclk(sclk), .dout(dout), .done(done), .rx(rx)
    );

    // Core clock at 40 ns and an unrelated host oscillator at 48 ns.
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        osc = 1'b0;
        #7;
        forever #24 osc = ~osc;
    end

    // Comparison tasks, one per kind of result.
    task automatic cmp_flag(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t flag got %b want %b", $time, got, exp);
        end
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t word got %h want %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Select the device and wait until it has powered up.
    task automatic pwr_up();
        int t;
        t = 0;
        @(posedge mclk);
        sel <= 1'b1;
        while (powered !== 1'b1 && t < 20) begin
            @(posedge mclk);
            #1;
            t++;
        end
        cmp_flag(powered, 1'b1);
        cmp_flag(dout_oe_n, 1'b0);
    endtask

    // Release the device and check that the line is quiet again.
    task automatic pwr_dn();
        @(posedge mclk);
        sel <= 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        cmp_flag(dout, 1'b0);
        cmp_flag(dout_oe_n, 1'b1);
        cmp_flag(powered, 1'b0);
        cmp_flag(sclk_overspeed, 1'b0);
    endtask

    // Clock n bits out of the device; the wait is bounded.
    task automatic shift(input int h, input int n);
        int t;
        t = 0;
        @(posedge mclk);
        half  <= h;
        nbits <= n;
        go    <= 1'b1;
        while (done !== 1'b1 && t < 3000) begin
            @(posedge mclk);
            t++;
        end
        go <= 1'b0;
        if (t >= 3000) begin
            miscompares++;
            $display("[ERR] %0t frame never completed", $time);
        end
        repeat (4) @(posedge mclk);
        #1;
    endtask

    // Start a conversion and check that it is busy one core cycle later.
    task automatic start_conv(input logic [13:0] c, input logic h,
                              input logic l);
        @(posedge mclk);
        adc_code   <= c;
        st_hi      <= h;
        st_lo      <= l;
        conv_start <= 1'b1;
        @(posedge mclk);
        conv_start <= 1'b0;
        #1;
        cmp_flag(conv_busy, 1'b1);
    endtask

    // Full result: convert, read n bits and compare with the model.
    task automatic run_result(input logic [13:0] c, input logic h,
                              input logic l, input int n);
        int cnt;
        cnt = 0;
        pwr_up();
        start_conv(c, h, l);
        while (conv_busy === 1'b1 && cnt < 300) begin
            @(posedge mclk);
            #1;
            cnt++;
        end
        cmp_word(cnt, CONV);
        repeat (3) @(posedge mclk);
        #1;
        cmp_flag(result_fresh, 1'b1);
        // Zero byte, code MSB first, then the two status bits, then zeros.
        exp_q.push_back(((int'(c) * 4) + (h * 2) + l) << (n - 24));
        shift(8, n);
        cmp_flag(result_fresh, 1'b0);
        cmp_word(rx, exp_q.pop_front());
        pwr_dn();
    endtask

    // Watchdog sized well above the longest expected run.
    initial begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        $display("[ERR] %0t run did not finish", $time);
        final_report();
    end

    initial begin
        logic [13:0] c;
        int t;
        miscompares = 0;
        n_checks    = 0;
        seed        = 32'hd3ee;
        rst = 1'b1;
        sel = 1'b0;
        go = 1'b0;
        half = 8;
        nbits = 24;
        conv_start = 1'b0;
        adc_code = 14'h0000;
        st_hi = 1'b0;
        st_lo = 1'b0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        cmp_flag(powered, 1'b0);
        cmp_flag(conv_busy, 1'b0);
        cmp_flag(result_fresh, 1'b0);
        cmp_flag(dout_oe_n, 1'b1);
        // A request while shut down must be ignored.
        @(posedge mclk);
        conv_start <= 1'b1;
        @(posedge mclk);
        conv_start <= 1'b0;
        #1;
        cmp_flag(conv_busy, 1'b0);
        // Boundary codes first, then random ones; one read runs long.
        for (int k = 0; k < 7; k++) begin
            c = (k == 0) ? 14'h0000 : (k == 1) ? 14'h3FFF : 14'($random(seed));
            run_result(c, 1'($random(seed)), 1'($random(seed)),
                       (k == 2) ? 32 : 24);
        end
        // Chip select rising mid-conversion ends it and shuts down.
        pwr_up();
        start_conv(14'h1A5C, 1'b1, 1'b0);
        @(posedge mclk);
        sel <= 1'b0;
        t = 0;
        while (conv_abort !== 1'b1 && t < 20) begin
            @(posedge mclk);
            #1;
            t++;
        end
        cmp_flag(conv_abort, 1'b1);
        cmp_flag(powered, 1'b0);
        cmp_flag(conv_busy, 1'b0);
        repeat (CONV + 4) @(posedge mclk);
        #1;
        cmp_flag(result_fresh, 1'b0);
        // A serial clock near 10 MHz breaks the speed limit.
        pwr_up();
        shift(1, 24);
        cmp_flag(sclk_overspeed, 1'b1);
        pwr_dn();
        final_report();
    end
endmodule // adcr_readout_tb
